// ==== switch_on_to_fault_pkg.sv ====
// Purpose: Shared constants and types for the switch-on-to-fault block
// Assumes: 50 MHz core clock, Avalon-MM register access with 32-bit data
// Notes: Window time held in milliseconds per setting group
package switch_on_to_fault_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int MS_TIME = 1; // Timebase unit in ms
    localparam int MS_CYCLES = CLK_HZ / 1000 * MS_TIME;
    localparam int MS_CNT_W = 16;
    localparam logic [20:0] WIN_MAX_MS = 21'h1b7740; // 1800.000 s
    localparam logic [20:0] WIN_DEF_MS = 21'h0003e8; // 1.000 s
    localparam int N_GRP = 8;
    localparam int LOG_DEPTH = 12;
    localparam int ADDR_W = 6;
    // Word byte addresses
    localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_STATE = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ST = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h0c;
    localparam logic [ADDR_W-1:0] OFS_WIN_TIME = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_LOG_SEL = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_LOG_A = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_LOG_B = 6'h1c;
    localparam logic [ADDR_W-1:0] OFS_EV_SEL = 6'h20;
    // Control fields
    localparam int CTRL_FORCE_LSB = 0;
    localparam int CTRL_FEN_BIT = 2;
    localparam int CTRL_GRP_LSB = 4;
    localparam logic [31:0] EV_SEL_RST = 32'h000000ff;
    // Events: bit 2k is ON, 2k+1 is OFF; k = init, block, active, trip
    localparam int N_EV = 8;
    typedef enum logic [1:0] {
        FRC_NORMAL = 2'h0,
        FRC_BLOCKED = 2'h1,
        FRC_ACTIVE = 2'h2,
        FRC_TRIP = 2'h3
    } switch_on_to_fault_force_type;
    typedef enum logic [2:0] {
        ST_NORMAL = 3'h0,
        ST_INIT = 3'h1,
        ST_ACTIVE = 3'h2,
        ST_TRIP = 3'h3,
        ST_BLOCKED = 3'h4
    } switch_on_to_fault_code_type;
    typedef struct packed {
        logic blocked;
        logic active;
        logic trip;
    } switch_on_to_fault_out_type;
    typedef struct packed {
        logic [2:0] group;
        logic [20:0] remain_ms;
        logic [20:0] elapsed_ms;
        logic [31:0] stamp;
    } switch_on_to_fault_log_type;
endpackage : switch_on_to_fault_pkg

// ==== switch_on_to_fault_tick.sv ====
// Purpose: Millisecond enable pulse from the core clock
// Assumes: Single core clock
// Notes: One-cycle pulse every MS_CYCLES cycles
`timescale 1ns/1ns
module switch_on_to_fault_tick import switch_on_to_fault_pkg::*; (
    input wire logic core_clk,
    input wire logic sys_rst,
    output logic ms_tick
);
    logic [MS_CNT_W-1:0] cnt_q;
    // Divider
    always_ff @(posedge core_clk) begin
        if (sys_rst || cnt_q == MS_CNT_W'(MS_CYCLES - 1)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
    assign ms_tick = (cnt_q == MS_CNT_W'(MS_CYCLES - 1));
endmodule : switch_on_to_fault_tick

// ==== switch_on_to_fault_log.sv ====
// Purpose: Twelve-entry circular log of activations
// Assumes: Write pulse from the core logic
// Notes: Index 0 reads the newest entry
`timescale 1ns/1ns
module switch_on_to_fault_log import switch_on_to_fault_pkg::*; (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input switch_on_to_fault_log_type wr_data,
    input wire logic [3:0] rd_idx,
    output switch_on_to_fault_log_type rd_data
);
    switch_on_to_fault_log_type mem_q [LOG_DEPTH];
    logic [3:0] wp_q;
    logic [3:0] slot;
    // Write pointer and storage
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wp_q <= '0;
        end else if (wr_en) begin
            mem_q[wp_q] <= wr_data;
            wp_q <= (wp_q == 4'(LOG_DEPTH - 1)) ? 4'h0 : wp_q + 4'h1;
        end
    end
    // Newest-first lookup
    always_comb begin
        slot = (wp_q > rd_idx) ? wp_q - rd_idx - 4'h1 : 4'(LOG_DEPTH) + wp_q - rd_idx - 4'h1;
        rd_data = (rd_idx < 4'(LOG_DEPTH)) ? mem_q[slot] : '0;
    end
endmodule : switch_on_to_fault_log

// ==== switch_on_to_fault_core.sv ====
// Purpose: Switch-on-to-fault arming, instant trip, status, events and log
// Assumes: Inputs arrive from pins; two flops before use
// Notes: Registers on Avalon-MM, one wait state on every access
`timescale 1ns/1ns
module switch_on_to_fault_core import switch_on_to_fault_pkg::*; (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic arm_in,
    input wire logic block_in,
    input wire logic [7:0] trigger_in,
    input wire logic [2:0] group_sel_in,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output switch_on_to_fault_out_type switch_on_to_fault_out,
    output logic [2:0] state_indication,
    output logic irq
);
    typedef enum logic [2:0] {
        FSM_IDLE = 3'b001,
        FSM_ARMED = 3'b010,
        FSM_TRIP = 3'b100
    } switch_on_to_fault_fsm_type;

    switch_on_to_fault_fsm_type fsm_q;
    logic [1:0] arm_s_q, blk_s_q;
    logic [7:0] trg_s0_q, trg_s1_q;
    logic [2:0] grp_s0_q, grp_s1_q;
    logic arm_d1_q;
    logic arm_rise, blk, trg_any, ms_tick;
    logic [20:0] remain_q, elapsed_q;
    logic [20:0] win_q [N_GRP];
    logic [1:0] force_sel_q;
    logic force_en_q;
    logic [2:0] grp_cfg_q;
    logic [2:0] grp_used;
    logic [N_EV-1:0] ev_st_q, ev_mask_q, ev_sel_q, ev_raw;
    logic [3:0] log_idx_q;
    logic [31:0] stamp_q;
    switch_on_to_fault_out_type raw_out, out_q, out_prev_q;
    logic init_q, init_prev_q;
    logic wait_q;
    logic acc, rd_load, log_wr;
    switch_on_to_fault_log_type log_rd, log_wd;

    function automatic logic [20:0] clip_ms(input logic [31:0] v);
        clip_ms = (v > 32'(WIN_MAX_MS)) ? WIN_MAX_MS : v[20:0];
    endfunction : clip_ms

    // Pin synchronisers, inputs are binary only
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            arm_s_q <= '0;
            blk_s_q <= '0;
            trg_s0_q <= '0;
            trg_s1_q <= '0;
            grp_s0_q <= '0;
            grp_s1_q <= '0;
            arm_d1_q <= 1'b0;
        end else begin
            arm_s_q <= {arm_s_q[0], arm_in};
            blk_s_q <= {blk_s_q[0], block_in};
            trg_s0_q <= trigger_in;
            trg_s1_q <= trg_s0_q;
            grp_s0_q <= group_sel_in;
            grp_s1_q <= grp_s0_q;
            arm_d1_q <= arm_s_q[1];
        end
    end
    assign arm_rise = arm_s_q[1] & ~arm_d1_q;
    assign blk = blk_s_q[1];
    assign trg_any = |trg_s1_q;
    assign grp_used = grp_s1_q | grp_cfg_q;

    switch_on_to_fault_tick u_tick (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .ms_tick(ms_tick)
    );

    // Armed window state machine
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fsm_q <= FSM_IDLE;
            remain_q <= '0;
            elapsed_q <= '0;
        end else begin
            case (fsm_q)
                FSM_IDLE: begin
                    if (arm_rise && !blk) begin
                        fsm_q <= FSM_ARMED;
                        remain_q <= win_q[grp_used];
                        elapsed_q <= '0;
                    end
                end
                FSM_ARMED: begin
                    if (blk) begin
                        fsm_q <= FSM_IDLE;
                    end else if (trg_any) begin
                        fsm_q <= FSM_TRIP;
                    end else if (remain_q == '0) begin
                        fsm_q <= FSM_IDLE;
                    end else if (ms_tick) begin
                        remain_q <= remain_q - 21'h1;
                        elapsed_q <= elapsed_q + 21'h1;
                    end
                end
                FSM_TRIP: begin
                    if (blk || !trg_any) begin
                        fsm_q <= FSM_IDLE;
                    end
                end
                default: fsm_q <= FSM_IDLE;
            endcase
        end
    end

    // Raw outputs, optionally forced
    always_comb begin
        raw_out.blocked = blk;
        raw_out.active = (fsm_q == FSM_ARMED) && !blk;
        // Trip stays up while a trigger holds, until the trigger releases or block is raised
        raw_out.trip = (fsm_q == FSM_ARMED || fsm_q == FSM_TRIP) && !blk && trg_any;
        if (force_en_q) begin
            raw_out.blocked = (force_sel_q == FRC_BLOCKED);
            raw_out.active = (force_sel_q == FRC_ACTIVE);
            raw_out.trip = (force_sel_q == FRC_TRIP);
        end
    end
    assign switch_on_to_fault_out = raw_out; // Instant trip path

    // Output history for event edges
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            out_q <= '0;
            out_prev_q <= '0;
            init_q <= 1'b0;
            init_prev_q <= 1'b0;
        end else begin
            out_q <= raw_out;
            out_prev_q <= out_q;
            init_q <= arm_rise && !blk;
            init_prev_q <= init_q;
        end
    end

    // ON and OFF events per condition
    assign ev_raw = {~out_q.trip & out_prev_q.trip, out_q.trip & ~out_prev_q.trip,
                     ~out_q.active & out_prev_q.active, out_q.active & ~out_prev_q.active,
                     ~out_q.blocked & out_prev_q.blocked, out_q.blocked & ~out_prev_q.blocked,
                     ~init_q & init_prev_q, init_q & ~init_prev_q};
    assign log_wr = out_q.active & ~out_prev_q.active;
    assign log_wd = '{group: grp_used, remain_ms: remain_q, elapsed_ms: elapsed_q,
                      stamp: stamp_q};

    // Status code
    always_comb begin
        if (force_en_q) begin
            case (force_sel_q)
                FRC_BLOCKED: state_indication = ST_BLOCKED;
                FRC_ACTIVE: state_indication = ST_ACTIVE;
                FRC_TRIP: state_indication = ST_TRIP;
                default: state_indication = ST_NORMAL;
            endcase
        end else if (blk) begin
            state_indication = ST_BLOCKED;
        end else if (raw_out.trip || fsm_q == FSM_TRIP) begin
            state_indication = ST_TRIP;
        end else if (init_q) begin
            state_indication = ST_INIT;
        end else if (raw_out.active) begin
            state_indication = ST_ACTIVE;
        end else begin
            state_indication = ST_NORMAL;
        end
    end

    switch_on_to_fault_log u_log (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wr_en(log_wr),
        .wr_data(log_wd),
        .rd_idx(log_idx_q),
        .rd_data(log_rd)
    );

    // Free-running ms time stamp
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stamp_q <= '0;
        end else if (ms_tick) begin
            stamp_q <= stamp_q + 32'h1;
        end
    end

    // Bus handshake, one wait state: read data loads in the wait cycle,
    // the access is taken at the edge where waitrequest is low
    assign acc = (avs_read || avs_write) && !wait_q;
    assign rd_load = avs_read && wait_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !(avs_read || avs_write) || !wait_q;
        end
    end
    assign avs_waitrequest = wait_q;

    // Configuration registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            force_sel_q <= FRC_NORMAL;
            force_en_q <= 1'b0;
            grp_cfg_q <= '0;
            ev_mask_q <= '0;
            ev_sel_q <= EV_SEL_RST[N_EV-1:0];
            log_idx_q <= '0;
            for (int i = 0; i < N_GRP; i++) begin
                win_q[i] <= WIN_DEF_MS;
            end
        end else if (acc && avs_write) begin
            case (avs_address)
                OFS_CTRL: begin
                    force_sel_q <= avs_writedata[CTRL_FORCE_LSB +: 2];
                    force_en_q <= avs_writedata[CTRL_FEN_BIT];
                    grp_cfg_q <= avs_writedata[CTRL_GRP_LSB +: 3];
                end
                OFS_IRQ_MASK: ev_mask_q <= avs_writedata[N_EV-1:0];
                OFS_WIN_TIME: win_q[grp_used] <= clip_ms(avs_writedata);
                OFS_LOG_SEL: log_idx_q <= avs_writedata[3:0];
                OFS_EV_SEL: ev_sel_q <= avs_writedata[N_EV-1:0];
                default: ;
            endcase
        end
    end

    // Sticky event status, set wins over read-clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ev_st_q <= '0;
        end else if (acc && avs_read && avs_address == OFS_IRQ_ST) begin
            // Clear only what the read returned, so nothing set in between is lost
            ev_st_q <= (ev_st_q & ~avs_readdata[N_EV-1:0]) | (ev_raw & ev_sel_q);
        end else begin
            ev_st_q <= ev_st_q | (ev_raw & ev_sel_q);
        end
    end
    assign irq = |(ev_st_q & ev_mask_q);

    // Read data
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            avs_readdata <= '0;
        end else if (rd_load) begin
            case (avs_address)
                OFS_CTRL: avs_readdata <= {25'h0, grp_cfg_q, 1'b0, force_en_q, force_sel_q};
                OFS_STATE: avs_readdata <= {26'h0, switch_on_to_fault_out, state_indication};
                OFS_IRQ_ST: avs_readdata <= {24'h0, ev_st_q};
                OFS_IRQ_MASK: avs_readdata <= {24'h0, ev_mask_q};
                OFS_WIN_TIME: avs_readdata <= {11'h0, win_q[grp_used]};
                OFS_LOG_SEL: avs_readdata <= {25'h0, log_rd.group, log_idx_q};
                OFS_LOG_A: avs_readdata <= {log_rd.remain_ms[10:0], log_rd.elapsed_ms};
                OFS_LOG_B: avs_readdata <= log_rd.stamp;
                OFS_EV_SEL: avs_readdata <= {24'h0, ev_sel_q};
                default: avs_readdata <= '0;
            endcase
        end
    end

    // Checks
    chk_trip_needs_arm: assert property (@(posedge core_clk) disable iff (sys_rst)
        switch_on_to_fault_out.trip && !force_en_q |-> (fsm_q == FSM_ARMED || fsm_q == FSM_TRIP) && trg_any)
        else $error("trip without armed window");
    chk_block_stops: assert property (@(posedge core_clk) disable iff (sys_rst)
        blk && !force_en_q |-> !switch_on_to_fault_out.trip && !switch_on_to_fault_out.active)
        else $error("output while blocked");
    chk_arm_start: assert property (@(posedge core_clk) disable iff (sys_rst)
        fsm_q == FSM_IDLE && arm_rise && !blk |=> fsm_q == FSM_ARMED && elapsed_q == 0)
        else $error("arming edge ignored");
    chk_window_load: assert property (@(posedge core_clk) disable iff (sys_rst)
        fsm_q == FSM_IDLE && arm_rise && !blk |=> remain_q == $past(win_q[grp_used]))
        else $error("window not loaded");
    chk_expire_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        fsm_q == FSM_ARMED && remain_q == 0 && !trg_any && !blk |=> fsm_q == FSM_IDLE)
        else $error("window did not end");
    chk_force_code: assert property (@(posedge core_clk) disable iff (sys_rst)
        force_en_q && force_sel_q == FRC_TRIP |-> state_indication == ST_TRIP)
        else $error("forced code wrong");
    chk_block_code: assert property (@(posedge core_clk) disable iff (sys_rst)
        !force_en_q && blk |-> state_indication == ST_BLOCKED)
        else $error("blocked code wrong");
    chk_trip_event: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(out_q.trip) && ev_sel_q[6] |=> ev_st_q[6])
        else $error("trip event lost");
    chk_irq_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        acc && avs_read && avs_address == OFS_IRQ_ST && ev_st_q == avs_readdata[N_EV-1:0]
        && (ev_raw & ev_sel_q) == '0 |=> !irq)
        else $error("status read did not clear irq");
    chk_log_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(switch_on_to_fault_out.active) |=> log_wr)
        else $error("activation not logged");
    cov_trip: cover property (@(posedge core_clk) disable iff (sys_rst)
        fsm_q == FSM_ARMED ##1 fsm_q == FSM_TRIP);
    cov_expire: cover property (@(posedge core_clk) disable iff (sys_rst)
        fsm_q == FSM_ARMED && remain_q == 0 ##1 fsm_q == FSM_IDLE);
    cov_block: cover property (@(posedge core_clk) disable iff (sys_rst)
        fsm_q == FSM_ARMED ##1 blk);
endmodule : switch_on_to_fault_core

// ==== switch_on_to_fault_pins_model.sv ====
// Purpose: Pin-level model of the protection starts and breaker close logic
// Assumes: Pins change just after a rising core_clk edge
// Notes: Plain binary levels only; no measured quantities reach the block
`timescale 1ns/1ns
module switch_on_to_fault_pins_model import switch_on_to_fault_pkg::*; (
    input wire logic core_clk,
    output logic arm_in,
    output logic block_in,
    output logic [7:0] trigger_in,
    output logic [2:0] group_sel_in
);
    // Quiet pins from time zero
    initial begin
        arm_in = 1'b0;
        block_in = 1'b0;
        trigger_in = 8'h00;
        group_sel_in = 3'h0;
    end

    // Set all pin levels together, right after a rising edge
    task automatic drive(input logic arm, input logic blk, input logic [7:0] trg,
                         input logic [2:0] grp);
        @(posedge core_clk);
        arm_in <= arm;
        block_in <= blk;
        trigger_in <= trg;
        group_sel_in <= grp;
    endtask : drive
endmodule : switch_on_to_fault_pins_model

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the switch-on-to-fault block
// Assumes: Window time set to 1 ms so expiry fits a short run
// Notes: Bus answers taken at the rising edge, pin outputs sampled on the falling edge
`timescale 1ns/1ns
module tb_top import switch_on_to_fault_pkg::*;;
    logic core_clk;
    logic sys_rst;
    logic arm_in;
    logic block_in;
    logic [7:0] trigger_in;
    logic [2:0] group_sel_in;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    switch_on_to_fault_out_type switch_on_to_fault_out;
    logic [2:0] state_indication;
    logic irq;
    int fail_count = 0;
    int samples_checked = 0;

    // Pin partner and block under test
    switch_on_to_fault_pins_model ptn (.core_clk(core_clk), .arm_in(arm_in), .block_in(block_in),
        .trigger_in(trigger_in), .group_sel_in(group_sel_in));
    switch_on_to_fault_core uut (.core_clk(core_clk), .sys_rst(sys_rst), .arm_in(arm_in),
        .block_in(block_in), .trigger_in(trigger_in), .group_sel_in(group_sel_in),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .switch_on_to_fault_out(switch_on_to_fault_out),
        .state_indication(state_indication), .irq(irq));

    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : wait_cyc

    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        logic w;
        n = 0;
        @(posedge core_clk);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        // Sample waitrequest as it stands at each rising edge
        do begin
            @(posedge core_clk);
            w = avs_waitrequest;
            n++;
        end while (w !== 1'b0 && n < 50);
        check(32'(w), 32'h0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(negedge core_clk);
    endtask : bus

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr_reg

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask : rd_chk

    task automatic t_reset;
        rd_chk(OFS_CTRL, 32'h0);
        rd_chk(OFS_STATE, 32'h0);
        rd_chk(OFS_EV_SEL, EV_SEL_RST);
        wr_reg(6'h24, 32'hffffffff);
        rd_chk(6'h24, 32'h0);
    endtask : t_reset

    task automatic t_win;
        rd_chk(OFS_WIN_TIME, {11'h0, WIN_DEF_MS});
        wr_reg(OFS_WIN_TIME, 32'h1);
        ptn.drive(1'b0, 1'b0, 8'h00, 3'h3);
        wait_cyc(4);
        wr_reg(OFS_WIN_TIME, 32'h001fffff);
        rd_chk(OFS_WIN_TIME, {11'h0, WIN_MAX_MS});
        ptn.drive(1'b0, 1'b0, 8'h00, 3'h1);
        wait_cyc(4);
        wr_reg(OFS_WIN_TIME, 32'h5);
        ptn.drive(1'b0, 1'b0, 8'h00, 3'h0);
        wait_cyc(4);
        rd_chk(OFS_WIN_TIME, 32'h1);
    endtask : t_win

    task automatic t_force;
        logic [2:0] codes [4] = '{3'h0, 3'h4, 3'h2, 3'h3};
        logic [2:0] outs [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
        for (int k = 0; k < 4; k++) begin
            wr_reg(OFS_CTRL, 32'h4 | 32'(k));
            wait_cyc(2);
            check(32'(state_indication), 32'(codes[k]));
            check(32'(switch_on_to_fault_out), 32'(outs[k]));
        end
        wr_reg(OFS_CTRL, 32'h3);
        wait_cyc(2);
        check(32'(state_indication), 32'h0);
        wr_reg(OFS_CTRL, 32'h0);
    endtask : t_force

    task automatic t_trip;
        logic [31:0] q;
        wr_reg(OFS_IRQ_MASK, 32'hff);
        bus(1'b0, OFS_IRQ_ST, 32'h0, q);
        check(32'(irq), 32'h0);
        ptn.drive(1'b1, 1'b0, 8'h00, 3'h0);
        wait_cyc(3);
        check(32'(switch_on_to_fault_out), 32'h2);
        check(32'(state_indication), 32'(ST_INIT));
        wait_cyc(2);
        check(32'(irq), 32'h1);
        bus(1'b0, OFS_IRQ_ST, 32'h0, q);
        check(q & 32'h10, 32'h10);
        check(32'(irq), 32'h0);
        ptn.drive(1'b1, 1'b0, 8'h20, 3'h0);
        wait_cyc(2);
        check(32'(switch_on_to_fault_out.trip), 32'h1);
        check(32'(state_indication), 32'(ST_TRIP));
        ptn.drive(1'b0, 1'b0, 8'h00, 3'h0);
        wait_cyc(4);
        check(32'(switch_on_to_fault_out), 32'h0);
        bus(1'b0, OFS_IRQ_ST, 32'h0, q);
        check(q & 32'h40, 32'h40);
    endtask : t_trip

    task automatic t_block;
        ptn.drive(1'b0, 1'b1, 8'h00, 3'h0);
        wait_cyc(3);
        check(32'(switch_on_to_fault_out), 32'h4);
        check(32'(state_indication), 32'(ST_BLOCKED));
        ptn.drive(1'b1, 1'b1, 8'h01, 3'h0);
        wait_cyc(4);
        check(32'(switch_on_to_fault_out), 32'h4);
        ptn.drive(1'b0, 1'b0, 8'h00, 3'h0);
        wait_cyc(3);
        check(32'(switch_on_to_fault_out), 32'h0);
    endtask : t_block

    task automatic t_log;
        logic [31:0] q;
        ptn.drive(1'b0, 1'b0, 8'h00, 3'h1);
        wait_cyc(3);
        ptn.drive(1'b1, 1'b0, 8'h00, 3'h1);
        wait_cyc(3);
        check(32'(switch_on_to_fault_out.active), 32'h1);
        ptn.drive(1'b1, 1'b1, 8'h00, 3'h1);
        wait_cyc(3);
        check(32'(switch_on_to_fault_out.active), 32'h0);
        wr_reg(OFS_LOG_SEL, 32'h0);
        bus(1'b0, OFS_LOG_SEL, 32'h0, q);
        check(q & 32'h70, 32'h10);
        ptn.drive(1'b0, 1'b0, 8'h00, 3'h0);
        wait_cyc(3);
    endtask : t_log

    task automatic t_expire;
        int n;
        logic [31:0] q;
        wr_reg(OFS_IRQ_MASK, 32'h0);
        bus(1'b0, OFS_IRQ_ST, 32'h0, q);
        ptn.drive(1'b1, 1'b0, 8'h00, 3'h0);
        wait_cyc(3);
        check(32'(switch_on_to_fault_out.active), 32'h1);
        check(32'(irq), 32'h0);
        n = 0;
        while (switch_on_to_fault_out.active !== 1'b0 && n < 60000) begin
            wait_cyc(1);
            n++;
        end
        check(32'(n < 60000), 32'h1);
        check(32'(state_indication), 32'h0);
        ptn.drive(1'b1, 1'b0, 8'h80, 3'h0);
        wait_cyc(3);
        check(32'(switch_on_to_fault_out.trip), 32'h0);
        bus(1'b0, OFS_IRQ_ST, 32'h0, q);
        check(q & 32'h10, 32'h10);
        ptn.drive(1'b0, 1'b0, 8'h00, 3'h0);
    endtask : t_expire

    // Reset, then the scenarios in order
    initial begin
        sys_rst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset;
        t_win;
        t_force;
        t_trip;
        t_block;
        t_log;
        t_expire;
        end_sim;
    end

    // Watchdog well beyond the longest window wait
    initial begin
        #1500000;
        fail_count++;
        end_sim;
    end
endmodule : tb_top
